/* File: src/rib_map.svh */
// Register map, field positions and reset values of the rate, interpolation and bypass bank.
// Assumes an AXI4-Lite slave that places register index N at byte address 4*N.
`ifndef RIB_MAP_SVH
`define RIB_MAP_SVH

// Register indices; byte address is four times the index
`define RIB_IDX_CORE       8'h09
`define RIB_IDX_FAST       8'h4e
`define RIB_IDX_INTP       8'h4f
`define RIB_IDX_BYP        8'h54
`define RIB_IDX_STAT       8'h55
`define RIB_ADDR_W         10

// Reset values
`define RIB_RST_CORE       8'h04
`define RIB_RST_FAST       3'h0
`define RIB_RST_INTP       5'h00
`define RIB_RST_BYP        6'h00

// Field positions
`define RIB_CORE_RUN_BIT   0
`define RIB_PROCESSING_RATE_SELECT_LSB    1
`define RIB_PROCESSING_RATE_SELECT_MSB    2
`define RIB_DIV_MSB        2
`define RIB_RATE_MSB       7
`define RIB_RATE_LSB       6
`define RIB_INTP_MSB       5
`define RIB_INTP_LSB       3
`define RIB_BYP_MSB        5

// Field codes and limits
`define RIB_FS_FAST        2'h3
`define RIB_DIV_LAST_CODE  3'h5
`define RIB_RESP_OKAY      2'h0
`define RIB_RESP_SLVERR    2'h2

`endif

/* File: src/rib_pkg.sv */
// Types and shared arithmetic of the rate, interpolation and bypass bank.
// Assumes nothing beyond a SystemVerilog compiler.
package rib_pkg;

    // Interpolation of one output channel
    typedef enum logic [1:0]
    {
        RIB_COMP = 2'h0,
        RIB_HOLD = 2'h1,
        RIB_LIN  = 2'h2
    } rib_interp_e;

    // Decoded converter and gain-path configuration
    typedef struct packed
    {
        rib_interp_e out1_interp;
        rib_interp_e out0_interp;
        logic        out1_gain_skip;
        logic        out0_gain_skip;
        logic        in3_gain_skip;
        logic        in2_gain_skip;
        logic        in1_gain_skip;
        logic        in0_gain_skip;
    } rib_mode_s;

    // Divide factor of a fast-rate divisor code; reserved codes fall back to 8
    function automatic logic [4:0] rib_div_of(input logic [2:0] code);
        logic [4:0] d;
        d = 5'h08;
        case (code)
            3'h0:    d = 5'h08;
            3'h1:    d = 5'h09;
            3'h2:    d = 5'h0a;
            3'h3:    d = 5'h0c;
            3'h4:    d = 5'h0e;
            3'h5:    d = 5'h10;
            default: d = 5'h08;
        endcase
        return d;
    endfunction

endpackage

/* File: src/rib_rate_div.sv */
// Fast-rate tick generator and output converter rate divider.
// Assumes the enable and divisor code are static while the processing core runs.
`timescale 1ns/10ps
`default_nettype none
module rib_rate_div
    import rib_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       enable,
    input  wire logic [2:0] div_code,
    input  wire logic [1:0] out_rate,
    output var  logic       fast_rate_tick,
    output var  logic       out_rate_tick
);
    logic [4:0] cnt;
    logic [2:0] sub;
    logic [2:0] sub_last;
    logic [4:0] div;
    logic [4:0] gap;
    logic       seen;

    assign div = rib_div_of(div_code);

    // Quarter and eighth rates; the reserved code runs at core rate
    always_comb
    begin
        unique case (out_rate)
            2'h1:    sub_last = 3'h3;
            2'h2:    sub_last = 3'h7;
            default: sub_last = 3'h0;
        endcase
    end

    // Master clock divided by the selected factor, only while enabled
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !enable)
        begin
            cnt            <= 5'h00;
            fast_rate_tick <= 1'b0;
        end
        else if (cnt == div - 5'h01) // R1 R2 R3
        begin
            cnt            <= 5'h00;
            fast_rate_tick <= 1'b1;
        end
        else
        begin
            cnt            <= cnt + 5'h01;
            fast_rate_tick <= 1'b0;
        end
    end

    // Output converter rate counts fast ticks
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !enable)
        begin
            sub           <= 3'h0;
            out_rate_tick <= 1'b0;
        end
        else
        begin
            out_rate_tick <= fast_rate_tick && (sub >= sub_last); // R6
            if (fast_rate_tick)
                sub <= (sub >= sub_last) ? 3'h0 : sub + 3'h1;
        end
    end

    // Helper: cycles since the previous fast tick
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !enable)
        begin
            gap  <= 5'h00;
            seen <= 1'b0;
        end
        else if (fast_rate_tick)
        begin
            gap  <= 5'h01;
            seen <= 1'b1;
        end
        else if (gap != 5'h1f)
            gap <= gap + 5'h01;
    end

    sequence s_tick_pair;
        seen && fast_rate_tick;
    endsequence

    a_tick_gap_div: assert property (@(posedge aclk) disable iff (!aresetn) // R2 R3
        s_tick_pair |-> gap == rib_div_of(div_code))
        else $error("Fast tick spacing differs from divisor");

    a_idle_no_tick: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        !enable |=> !fast_rate_tick && !out_rate_tick)
        else $error("Tick while fast rate disabled");

    a_eighth_rate: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        enable && out_rate == 2'h2 && out_rate_tick && $stable(enable)
            |-> ##1 !out_rate_tick [*7])
        else $error("Eighth rate tick too soon");

endmodule
`default_nettype wire

/* File: src/rib_mode_dec.sv */
// Decoder from interpolation and bypass fields to per-channel converter settings.
// Assumes the fields come straight from the register bank.
`timescale 1ns/10ps
`default_nettype none
module rib_mode_dec
    import rib_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [2:0]          interp_code,
    input  wire logic [5:0]          skip_bits,
    output var  rib_pkg::rib_mode_s  mode
);
    rib_mode_s next_mode;

    // Interpolation code to channel modes; code 7 is reserved and stays compensated
    always_comb
    begin
        next_mode = '0;
        unique case (interp_code)
            3'h1:    next_mode.out0_interp = RIB_HOLD; // R7
            3'h2:    next_mode.out1_interp = RIB_HOLD; // R7
            3'h3:
            begin
                next_mode.out0_interp = RIB_HOLD; // R7
                next_mode.out1_interp = RIB_HOLD;
            end
            3'h4:    next_mode.out0_interp = RIB_LIN; // R8
            3'h5:    next_mode.out1_interp = RIB_LIN; // R8
            3'h6:
            begin
                next_mode.out0_interp = RIB_LIN; // R8
                next_mode.out1_interp = RIB_LIN;
            end
            default: next_mode.out0_interp = RIB_COMP; // R11
        endcase
        next_mode.out1_gain_skip = skip_bits[5]; // R9
        next_mode.out0_gain_skip = skip_bits[4]; // R9
        next_mode.in3_gain_skip  = skip_bits[3]; // R10
        next_mode.in2_gain_skip  = skip_bits[2]; // R10
        next_mode.in1_gain_skip  = skip_bits[1]; // R10
        next_mode.in0_gain_skip  = skip_bits[0]; // R10
    end

    // Registered so the converters see glitch-free settings
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mode <= '0;
        else
            mode <= next_mode;
    end

    a_interp_hold_map: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        interp_code == 3'h3 |=> mode.out0_interp == RIB_HOLD && mode.out1_interp == RIB_HOLD)
        else $error("Code 3 not both sample hold");

    a_interp_lin_map: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        interp_code == 3'h5 |=> mode.out0_interp == RIB_COMP && mode.out1_interp == RIB_LIN)
        else $error("Code 5 mapping wrong");

    a_skip_out_bits: assert property (@(posedge aclk) disable iff (!aresetn) // R9
        ##1 mode.out1_gain_skip == $past(skip_bits[5]) && mode.out0_gain_skip == $past(skip_bits[4]))
        else $error("Output gain skip mismatch");

    a_skip_in_bits: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        ##1 {mode.in3_gain_skip, mode.in2_gain_skip, mode.in1_gain_skip, mode.in0_gain_skip}
            == $past(skip_bits[3:0]))
        else $error("Input gain skip mismatch");

endmodule
`default_nettype wire

/* File: src/rib_top.sv */
// AXI4-Lite register bank for the fast processing rate, output interpolation and gain bypass.
// Assumes aclk is the internal master clock domain and the bus master keeps AXI handshakes.
//
// Contract
// R1 - Fast divisor applies only when rate select 11
// R2 - Codes 000,001,010 divide by 8,9,10
// R3 - Codes 011,100,101 divide by 12,14,16
// R4 - Host keeps divisor fixed while core runs
// R5 - Divisor update accepted only with run cleared
// R6 - Bits 7:6 pick core, quarter, eighth rate
// R7 - Interp codes 000-011 select compensated or hold
// R8 - Interp codes 100-110 select linear per channel
// R9 - Bits 5,4 skip output channel gain
// R10 - Bits 3..0 skip input channel gain
// R11 - Reserved codes not written, treated as reserved
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "rib_map.svh"
module rib_top
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [`RIB_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output var  logic                    s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output var  logic                    s_axi_wready,
    output var  logic [1:0]              s_axi_bresp,
    output var  logic                    s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`RIB_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output var  logic                    s_axi_arready,
    output var  logic [31:0]             s_axi_rdata,
    output var  logic [1:0]              s_axi_rresp,
    output var  logic                    s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output var  logic                    fast_rate_tick,
    output var  logic                    out_rate_tick,
    output var  rib_pkg::rib_mode_s      mode
);
    import rib_pkg::*;

    logic [7:0] core_ctrl;
    logic [2:0] fast_ctrl;
    logic [4:0] intp_ctrl;
    logic [5:0] byp_ctrl;

    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_idx;
    logic [7:0] w_byte;
    logic       w_lane0;
    logic       next_aw_held;
    logic       next_w_held;
    logic       next_bvalid;
    logic       next_rvalid;
    logic       aw_hs;
    logic       w_hs;
    logic       ar_hs;
    logic       do_write;
    logic       wr_en;
    logic [7:0] ar_idx;
    logic [7:0] rd_byte;
    logic       core_run;
    logic [1:0] processing_rate_select;
    logic       fast_active;

    // Word index of a byte address; the low two bits do not select anything
    function automatic logic [7:0] idx_of(input logic [`RIB_ADDR_W-1:0] addr);
        return addr[`RIB_ADDR_W-1:2];
    endfunction

    // Index decode shared by the read and write paths
    function automatic logic idx_known(input logic [7:0] idx);
        return idx == `RIB_IDX_CORE || idx == `RIB_IDX_FAST || idx == `RIB_IDX_INTP
            || idx == `RIB_IDX_BYP || idx == `RIB_IDX_STAT;
    endfunction

    assign core_run               = core_ctrl[`RIB_CORE_RUN_BIT];
    assign processing_rate_select = core_ctrl[`RIB_PROCESSING_RATE_SELECT_MSB:`RIB_PROCESSING_RATE_SELECT_LSB];
    assign fast_active            = core_run && processing_rate_select == `RIB_FS_FAST; // R1

    // Handshake terms
    assign aw_hs    = s_axi_awvalid && s_axi_awready;
    assign w_hs     = s_axi_wvalid && s_axi_wready;
    assign ar_hs    = s_axi_arvalid && s_axi_arready;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_en    = do_write && w_lane0;

    // Address and data are taken in either order and held until the write fires
    always_comb
    begin
        next_aw_held = (aw_held || aw_hs) && !do_write;
        next_w_held  = (w_held || w_hs) && !do_write;
        next_bvalid  = do_write || (s_axi_bvalid && !s_axi_bready);
        next_rvalid  = ar_hs || (s_axi_rvalid && !s_axi_rready);
    end

    // Write channel holding state and registered readies
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_idx        <= 8'h00;
            w_byte        <= 8'h00;
            w_lane0       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready  <= !next_w_held && !next_bvalid;
            if (aw_hs)
                aw_idx <= idx_of(s_axi_awaddr);
            if (w_hs)
            begin
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
        end
    end

    // Write response; read-only or unmapped words answer with a slave error
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RIB_RESP_OKAY;
        end
        else
        begin
            s_axi_bvalid <= next_bvalid;
            if (do_write)
                s_axi_bresp <= (idx_known(aw_idx) && aw_idx != `RIB_IDX_STAT)
                    ? `RIB_RESP_OKAY : `RIB_RESP_SLVERR;
        end
    end

    // Core control word carries the run bit and the rate select
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            core_ctrl <= `RIB_RST_CORE;
        else if (wr_en && aw_idx == `RIB_IDX_CORE)
            core_ctrl <= w_byte;
    end

    // Divisor is frozen while the core runs; reserved codes are dropped too
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fast_ctrl <= `RIB_RST_FAST;
        else if (wr_en && aw_idx == `RIB_IDX_FAST && !core_run // R5 R4
            && w_byte[`RIB_DIV_MSB:0] <= `RIB_DIV_LAST_CODE) // R11
            fast_ctrl <= w_byte[`RIB_DIV_MSB:0];
    end

    // Output rate and interpolation fields; low three bits are reserved
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            intp_ctrl <= `RIB_RST_INTP;
        else if (wr_en && aw_idx == `RIB_IDX_INTP)
            intp_ctrl <= w_byte[`RIB_RATE_MSB:`RIB_INTP_LSB]; // R6 R7 R8
    end

    // Gain bypass bits; top two bits are reserved
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            byp_ctrl <= `RIB_RST_BYP;
        else if (wr_en && aw_idx == `RIB_IDX_BYP)
            byp_ctrl <= w_byte[`RIB_BYP_MSB:0]; // R9 R10
    end

    // Read data; status shows whether the fast rate runs and its divide factor
    assign ar_idx = idx_of(s_axi_araddr);
    always_comb
    begin
        rd_byte = 8'h00;
        unique case (ar_idx)
            `RIB_IDX_CORE: rd_byte = core_ctrl;
            `RIB_IDX_FAST: rd_byte = {5'h00, fast_ctrl};
            `RIB_IDX_INTP: rd_byte = {intp_ctrl, 3'h0};
            `RIB_IDX_BYP:  rd_byte = {2'h0, byp_ctrl};
            `RIB_IDX_STAT: rd_byte = {fast_active, 2'h0, rib_div_of(fast_ctrl)};
            default:       rd_byte = 8'h00;
        endcase
    end

    // Read channel: one read at a time, answered the cycle after it is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RIB_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_hs)
            begin
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= idx_known(ar_idx) ? `RIB_RESP_OKAY : `RIB_RESP_SLVERR;
            end
        end
    end

    // Rate tick generation from the master clock
    rib_rate_div u_rate_div
    (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .enable         (fast_active),
        .div_code       (fast_ctrl),
        .out_rate       (intp_ctrl[4:3]),
        .fast_rate_tick (fast_rate_tick),
        .out_rate_tick  (out_rate_tick)
    );

    // Per-channel interpolation and gain bypass settings
    rib_mode_dec u_mode_dec
    (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .interp_code (intp_ctrl[2:0]),
        .skip_bits   (byp_ctrl),
        .mode        (mode)
    );

    sequence s_write_ready;
        aw_held && w_held && !s_axi_bvalid;
    endsequence

    sequence s_write_answer;
        s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endsequence

    a_write_resp_time: assert property (@(posedge aclk) disable iff (!aresetn)
        s_write_ready |=> s_write_answer)
        else $error("Write response not given one cycle after both halves held");

    a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped before taken");

    a_read_resp_time: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_hs |=> s_axi_rvalid && !s_axi_arready)
        else $error("Read data not valid after address taken");

    a_div_run_lock: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        core_run |=> $stable(fast_ctrl))
        else $error("Divisor changed while core running");

    a_div_idle_load: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        wr_en && aw_idx == `RIB_IDX_FAST && !core_run && w_byte[2:0] <= 3'h5
            |=> fast_ctrl == $past(w_byte[2:0]))
        else $error("Divisor write lost while core stopped");

    a_div_no_rsvd: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        fast_ctrl <= 3'h5)
        else $error("Reserved divisor code stored");

    a_fast_gate_sel: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        processing_rate_select != 2'h3 ##1 processing_rate_select != 2'h3 |=> !fast_rate_tick)
        else $error("Fast tick without fast rate selected");

    // Bus holding, tick gating and core rate output tick checks
    a_read_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped before taken");

    a_ready_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write ready while response pending");

    a_tick_run_only: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        !core_run |=> !fast_rate_tick)
        else $error("Fast tick while core stopped");

    a_core_rate_out: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        fast_active && intp_ctrl[4:3] == 2'h0 && fast_rate_tick |=> out_rate_tick)
        else $error("Core rate output tick missing");

endmodule
`default_nettype wire

/* File: verification/tb_rate_interp_bypass_config.sv */
// Self-checking bench for the rate, interpolation and bypass register bank.
// Assumes rib_top with the register map header; drives AXI4-Lite itself.
`timescale 1ns/10ps
`default_nettype none
`include "rib_map.svh"
module tb_rate_interp_bypass_config;
    import rib_pkg::*;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [9:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0]  s_axi_wstrb = '0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        fast_rate_tick, out_rate_tick;
    rib_mode_s   mode;
    logic [1:0]  exp_b [$];
    logic [33:0] exp_r [$];
    logic [33:0] e;
    logic [5:0]  byp = '0;
    logic [2:0]  intp = '0;
    int          bad_count = 0;
    int          num_checks = 0;

    rib_top u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .fast_rate_tick(fast_rate_tick), .out_rate_tick(out_rate_tick), .mode(mode)
    );

    // 125 MHz clock
    always #4 aclk = ~aclk;

    // One mismatch line per failed comparison
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp({30'h0, got}, {30'h0, exp}, "resp");
    endtask

    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        cmp(got, exp, "rdata");
    endtask

    task automatic cmp_mode(input rib_mode_s got, input rib_mode_s exp);
        cmp({22'h0, got}, {22'h0, exp}, "mode");
    endtask

    // Expected decode, written out per code rather than shared with the design
    function automatic rib_mode_s exp_mode();
        rib_mode_s m;
        m = '0;
        case (intp)
            3'h1: m.out0_interp = RIB_HOLD;
            3'h2: m.out1_interp = RIB_HOLD;
            3'h3:
            begin
                m.out0_interp = RIB_HOLD;
                m.out1_interp = RIB_HOLD;
            end
            3'h4: m.out0_interp = RIB_LIN;
            3'h5: m.out1_interp = RIB_LIN;
            3'h6:
            begin
                m.out0_interp = RIB_LIN;
                m.out1_interp = RIB_LIN;
            end
            default: m.out0_interp = RIB_COMP;
        endcase
        {m.out1_gain_skip, m.out0_gain_skip, m.in3_gain_skip,
         m.in2_gain_skip, m.in1_gain_skip, m.in0_gain_skip} = byp;
        return m;
    endfunction

    // Write: address and data offered together, bready held until bvalid
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st,
                      input logic [1:0] er);
        int i;
        exp_b.push_back(er);
        @(posedge aclk);
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_wdata   <= {24'($urandom()), d};
        s_axi_wstrb   <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        i = 0;
        do
        begin
            @(posedge aclk);
            i++;
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1 && i < 100);
        s_axi_bready <= 1'b0;
        if (i >= 100) cmp(32'h0, 32'h1, "write wait");
    endtask

    // Read: expectation queued for the monitor
    task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        int i;
        exp_r.push_back({er, 24'h0, d});
        @(posedge aclk);
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        i = 0;
        do
        begin
            @(posedge aclk);
            i++;
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1 && i < 100);
        s_axi_rready <= 1'b0;
        if (i >= 100) cmp(32'h0, 32'h1, "read wait");
    endtask

    // Cycles between two consecutive pulses of a tick output
    task automatic gap(input bit sel, output int n);
        int i;
        i = 0;
        while ((sel ? out_rate_tick : fast_rate_tick) !== 1'b1 && i < 400)
        begin
            @(posedge aclk);
            i++;
        end
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while ((sel ? out_rate_tick : fast_rate_tick) !== 1'b1 && n < 400);
    endtask

    // Monitor takes the oldest note whenever a response is handed over
    always @(posedge aclk)
    begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && exp_b.size() > 0)
            cmp_resp(s_axi_bresp, exp_b.pop_front());
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && exp_r.size() > 0)
        begin
            e = exp_r.pop_front();
            cmp_resp(s_axi_rresp, e[33:32]);
            cmp_data(s_axi_rdata, e[31:0]);
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog well beyond the thousand or so cycles the sequence needs
    initial
    begin
        repeat (40000) @(posedge aclk);
        bad_count++;
        complete_run();
    end

    initial
    begin
        static int divs [6] = '{8, 9, 10, 12, 14, 16};
        static int grp [3] = '{1, 4, 8};
        int n, t;
        void'($urandom(62));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values and refused accesses
        rd(`RIB_IDX_CORE, 8'h04, 2'h0);
        rd(`RIB_IDX_FAST, 8'h00, 2'h0);
        rd(`RIB_IDX_INTP, 8'h00, 2'h0);
        rd(`RIB_IDX_BYP, 8'h00, 2'h0);
        cmp_mode(mode, exp_mode());
        rd(8'h10, 8'h00, 2'h2);
        wr(`RIB_IDX_STAT, 8'hff, 4'hf, 2'h2);
        // Each skip bit alone, then random patterns; reserved bits read zero
        for (int i = 0; i < 9; i++)
        begin
            byp = (i < 6) ? 6'(1 << i) : 6'($urandom());
            wr(`RIB_IDX_BYP, {2'b11, byp}, 4'hf, 2'h0);
            rd(`RIB_IDX_BYP, {2'b00, byp}, 2'h0);
            cmp_mode(mode, exp_mode());
        end
        wr(`RIB_IDX_BYP, ~{2'b00, byp}, 4'he, 2'h0);
        rd(`RIB_IDX_BYP, {2'b00, byp}, 2'h0);
        // Interpolation codes 0 to 6, each with one output rate code, cycling 0, 1, 2
        for (int c = 0; c < 7; c++)
        begin
            intp = 3'(c);
            wr(`RIB_IDX_INTP, {2'(c % 3), intp, 3'b111}, 4'hf, 2'h0);
            rd(`RIB_IDX_INTP, {2'(c % 3), intp, 3'b000}, 2'h0);
            cmp_mode(mode, exp_mode());
        end
        intp = 3'h0;
        // Every divisor code: tick spacing, output grouping, locked while running
        for (int c = 0; c < 6; c++)
        begin
            wr(`RIB_IDX_FAST, 8'(c), 4'hf, 2'h0);
            wr(`RIB_IDX_INTP, {2'(c % 3), 6'h00}, 4'hf, 2'h0);
            wr(`RIB_IDX_CORE, 8'h07, 4'hf, 2'h0);
            rd(`RIB_IDX_STAT, {3'b100, 5'(divs[c])}, 2'h0);
            gap(1'b0, n);
            cmp(32'(n), 32'(divs[c]), "fast gap");
            gap(1'b1, n);
            cmp(32'(n), 32'(divs[c] * grp[c % 3]), "out gap");
            wr(`RIB_IDX_FAST, 8'((c + 1) % 6), 4'hf, 2'h0);
            rd(`RIB_IDX_FAST, 8'(c), 2'h0);
            wr(`RIB_IDX_CORE, 8'h04, 4'hf, 2'h0);
        end
        wr(`RIB_IDX_FAST, 8'h06, 4'hf, 2'h0);
        rd(`RIB_IDX_FAST, 8'h05, 2'h0);
        // Running with another rate select gives no fast ticks
        wr(`RIB_IDX_CORE, 8'h05, 4'hf, 2'h0);
        t = 0;
        repeat (60)
        begin
            @(posedge aclk);
            if (fast_rate_tick !== 1'b0) t++;
        end
        cmp(32'(t), 32'h0, "idle ticks");
        rd(`RIB_IDX_STAT, 8'h10, 2'h0);
        complete_run();
    end
endmodule
`default_nettype wire
